// ==== eirqnf_pin_src.sv ====
// Purpose: external pin source making clean pulses and glitches
// Assumes: pulse lengths in ref_clk cycles, started after an edge
// Notes: pin idles low between pulses
`default_nettype none
module eirqnf_pin_src (
   // clock and pin
   input wire logic ref_clk,
   output logic pin
);
   timeunit 1ns;
   timeprecision 1ns;
   initial pin = 1'b0;
   task automatic pulse(int len);
      pin <= 1'b1;
      repeat (len) @(posedge ref_clk);
      pin <= 1'b0;
   endtask
endmodule // eirqnf_pin_src
`default_nettype wire

// ==== eirqnf_pkg.sv ====
// Purpose: constants for the external interrupt 1 noise filter
// Assumes: 10 MHz ref_clk; 32-bit Avalon-MM register bus
// Notes: byte addresses of word-aligned registers
`default_nettype none
package eirqnf_pkg;
   // register byte offsets
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_MASK = 4'h8;
   localparam logic [3:0] ADDR_MODE = 4'hc;
   // control field positions
   localparam int NC_LSB = 0;
   localparam int ES_LSB = 2;
   localparam int LVL_BIT = 4;
   // values after reset
   localparam logic [4:0] CTRL_RST = 5'h00;
   localparam logic [1:0] MASK_RST = 2'h0;
   localparam logic [1:0] STATUS_RST = 2'h0;
   localparam logic MODE_RST = 1'b0;
   // sampling dividers in gear clock cycles
   localparam logic [3:0] DIV_1 = 4'h0;
   localparam logic [3:0] DIV_4 = 4'h3;
   localparam logic [3:0] DIV_8 = 4'h7;
   localparam logic [3:0] DIV_16 = 4'hf;
   // low-speed sampling at low_freq_clock / 4 (edges of that clock)
   localparam logic [1:0] LF_DIV = 2'h3;
   // edge select codes
   localparam logic [1:0] ES_RISE = 2'h0;
   localparam logic [1:0] ES_FALL = 2'h1;
   localparam logic [1:0] ES_BOTH = 2'h2;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ACK = 2'b01
   } eirqnf_bus_t;
endpackage
`default_nettype wire

// ==== eirqnf_props.sv ====
// Purpose: bus, request and read-back checks on the filter top
// Assumes: one clock domain, reset low active
// Notes: bound to every eirqnf_top
`default_nettype none
module eirqnf_props (
   // clock, reset and pins
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic ext_irq1_pin,
   input wire logic low_freq_clock,
   // register bus
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic waitrequest,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   // interrupt
   input wire logic ext_irq1_req,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wire logic rd_ok = read && !waitrequest;
   a_wait_first: assert property ((read || write) && waitrequest
      |=> !waitrequest) else $error("no answer after one wait state");
   a_idle_nowait: assert property (!read && !write |-> !waitrequest)
      else $error("waitrequest high while idle");
   a_req_single: assert property (
      ext_irq1_req |=> !ext_irq1_req) else $error("request not a pulse");
   a_ctrl_hi_zero: assert property (
      rd_ok && address == 4'h0 |-> readdata[31:5] == 27'h0)
      else $error("control high bits not zero");
   a_unmapped_zero: assert property (rd_ok && address[1:0] != 2'h0
      |-> readdata == 32'h0) else $error("unmapped read not zero");
   a_status_hi: assert property (rd_ok && address == 4'h4
      |-> readdata[31:2] == 30'h0) else $error("status high bits set");
   a_mask_off: assert property (write && !waitrequest && address == 4'h8
      && writedata[1:0] == 2'h0 |=> !irq) else $error("irq with mask 0");
   a_data_hold: assert property (!read |=> $stable(readdata))
      else $error("read data moved without a read");
endmodule // eirqnf_props
bind eirqnf_top eirqnf_props u_props (.ref_clk, .rst_n, .ext_irq1_pin,
   .low_freq_clock, .address, .read, .write, .writedata, .readdata,
   .waitrequest, .ext_irq1_req, .irq);
`default_nettype wire

// ==== eirqnf_test.sv ====
// Purpose: self-checking bench of the external interrupt 1 filter
// Assumes: low_freq_clock period is 8 ref_clk cycles
// Notes: pulse counts come from a model of the sampling filter
`default_nettype none
module ext_irq1_noise_filter_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 0, rst_n = 0, low_freq_clock = 0, read = 0, write = 0;
   logic [3:0] address = 4'h0;
   logic [31:0] writedata = 32'h0, q, rs_state = 32'h60;
   wire logic [31:0] readdata;
   wire logic waitrequest, ext_irq1_req, irq, pin;
   int mismatches = 0, compares = 0, nreq = 0, n0, d, lf = 0;
   int div_q[$] = '{1, 4, 8, 16};
   logic [3:0] regs[5] = '{4'h0, 4'h4, 4'h8, 4'hc, 4'h2};
   eirqnf_top u_dut (.ref_clk, .rst_n, .ext_irq1_pin(pin), .low_freq_clock,
      .address, .read, .write, .writedata, .readdata, .waitrequest,
      .ext_irq1_req, .irq);
   eirqnf_pin_src u_pin (.ref_clk, .pin);
   initial forever #50 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      lf <= lf + 1;
      low_freq_clock <= lf[2];
      if (ext_irq1_req === 1'b1) nreq <= nreq + 1;
   end
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(logic [31:0] seen, logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task automatic bus(logic w, logic [3:0] a, logic [31:0] dat);
      int n;
      read <= !w;
      write <= w;
      address <= a;
      writedata <= dat;
      for (n = 0; n < 20; n++) begin
         @(posedge ref_clk);
         if (waitrequest === 1'b0) break;
      end
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      if (n == 20) begin
         mismatches++;
         give_verdict();
      end else begin
         @(posedge ref_clk);
      end
   endtask
   function automatic logic [31:0] rnd();
      rs_state ^= rs_state << 13;
      rs_state ^= rs_state >> 17;
      rs_state ^= rs_state << 5;
      return rs_state;
   endfunction
   function automatic int want(int es, int lng);
      if (lng == 0 || es == 3) return 0;
      return (es == 2) ? 2 : 1;
   endfunction
   initial begin
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      foreach (regs[i]) begin
         bus(0, regs[i], 32'h0);
         chk(q, 32'h0);
      end
      bus(1, 4'h0, 32'hff);
      bus(0, 4'h0, 32'h0);
      chk(q, 32'h0f);
      for (int m = 0; m < 3; m++) begin
         bus(1, 4'h8, 32'h0);
         bus(1, 4'hc, m % 2);
         repeat (100) @(posedge ref_clk);
         for (int c = 0; c < 16; c++) begin
            bus(1, 4'h8, 32'h0);
            bus(1, 4'h0, c);
            repeat (40) @(posedge ref_clk);
            bus(0, 4'h4, 32'h0);
            chk(q[1], c == 0 && m > 0);
            bus(1, 4'h8, 32'h1);
            d = (m == 1) ? 32 : div_q[c % 4];
            for (int l = 0; l < 2; l++) begin
               n0 = nreq;
               u_pin.pulse(l ? 2 * d + 2 + rnd() % 4 : (d == 1 ? 1 : d - 1));
               repeat (3 * d + 12) @(posedge ref_clk);
               chk(nreq - n0, want(c / 4, l));
            end
            chk(irq, want(c / 4, 1) > 0);
            bus(0, 4'h4, 32'h0);
            chk(q[0], want(c / 4, 1) > 0);
            chk(irq, 32'h0);
         end
      end
      give_verdict();
   end
endmodule // ext_irq1_noise_filter_test
`default_nettype wire

// ==== eirqnf_top.sv ====
// Purpose: external interrupt 1 input noise canceller and edge detector
// Assumes: ref_clk is the gear clock; low_freq_clock arrives as a level
// Notes: a status read clears what it reported; one wait state per transfer
// Summary of operation
// - high speed: sample_rate_sel picks gear clock divided by 1, 4, 8, 16.
// - low speed: sample at low_freq_clock divided by four regardless of field.
// - a spurious request may appear while the clock mode switches.
// - control bits seven to five read as zero.
// - edge_sel 10 requests on both edges; code 11 is reserved, no request.
//
// The placing of the registers and the Avalon-MM register port were decided locally.
`default_nettype none
module eirqnf_top (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // pins
   input wire logic ext_irq1_pin,
   input wire logic low_freq_clock,
   // avalon-mm slave
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // interrupt
   output logic ext_irq1_req,
   output logic irq
);
   logic [1:0] pin_sync;
   logic [1:0] lfc_sync;
   logic lfc_prev;
   logic [4:0] ext_irq1_control_reg;
   logic [1:0] mask;
   logic [1:0] status;
   logic low_speed;
   logic [3:0] div_cnt;
   logic [1:0] lf_cnt;
   logic last_sample;
   logic pass;
   logic pass_prev;
   eirqnf_pkg::eirqnf_bus_t bus_state;

   function automatic logic [3:0] div_of(input logic [1:0] sel);
      case (sel)
         2'h0: div_of = eirqnf_pkg::DIV_1;
         2'h1: div_of = eirqnf_pkg::DIV_4;
         2'h2: div_of = eirqnf_pkg::DIV_8;
         default: div_of = eirqnf_pkg::DIV_16;
      endcase
   endfunction

   wire [1:0] ext_irq1_sample_rate_sel =
      ext_irq1_control_reg[eirqnf_pkg::NC_LSB +: 2];
   wire [1:0] ext_irq1_edge_sel =
      ext_irq1_control_reg[eirqnf_pkg::ES_LSB +: 2];
   wire lf_rise = lfc_sync[1] & ~lfc_prev;
   wire hs_tick = (div_cnt == div_of(ext_irq1_sample_rate_sel));
   // low speed ignores the rate field
   wire ls_tick = lf_rise && (lf_cnt == eirqnf_pkg::LF_DIV);
   wire tick = low_speed ? ls_tick : hs_tick;
   wire rise = pass & ~pass_prev;
   wire fall = ~pass & pass_prev;
   wire both_hit = rise | fall;
   // the reserved edge code raises nothing
   wire edge_hit =
      (ext_irq1_edge_sel == eirqnf_pkg::ES_RISE) ? rise :
      (ext_irq1_edge_sel == eirqnf_pkg::ES_FALL) ? fall :
      (ext_irq1_edge_sel == eirqnf_pkg::ES_BOTH) ? both_hit :
      1'b0;

   // one wait state; a transfer takes effect in its answer cycle
   wire bus_new = (read | write) && (bus_state == eirqnf_pkg::BUS_IDLE);
   wire bus_done = (read | write) && (bus_state == eirqnf_pkg::BUS_ACK);
   wire wr_done = bus_done && write;
   wire rd_done = bus_done && read;
   wire wr_ctrl = wr_done && (address == eirqnf_pkg::ADDR_CTRL);
   wire wr_mask = wr_done && (address == eirqnf_pkg::ADDR_MASK);
   wire wr_mode = wr_done && (address == eirqnf_pkg::ADDR_MODE);
   wire rd_stat = rd_done && (address == eirqnf_pkg::ADDR_STATUS);

   // status bit 0: selected edge, bit 1: mode switch (possible spurious)
   wire mode_chg = wr_mode && (writedata[0] != low_speed);
   wire [1:0] events = {mode_chg, edge_hit};
   // a read clears only the bits it reported, so late events stay set
   wire [1:0] rd_clear = rd_stat ? readdata[1:0] : 2'h0;
   wire [1:0] next_status = (status & ~rd_clear) | events;
   wire [1:0] next_mask = wr_mask ? writedata[1:0] : mask;
   wire [31:0] ctrl_word = {27'h0, ext_irq1_control_reg};
   wire [31:0] next_readdata =
      (address == eirqnf_pkg::ADDR_CTRL) ? ctrl_word :
      (address == eirqnf_pkg::ADDR_STATUS) ? {30'h0, status} :
      (address == eirqnf_pkg::ADDR_MASK) ? {30'h0, mask} :
      (address == eirqnf_pkg::ADDR_MODE) ? {31'h0, low_speed} : 32'h0;

   assign waitrequest = bus_new;

   // two flip-flops on the pin before the canceller reads it
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         pin_sync <= 2'h0;
      else
         pin_sync <= {pin_sync[0], ext_irq1_pin};
   end

   // low clock arrives as a level; edges found after the second flop
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         lfc_sync <= 2'h0;
         lfc_prev <= 1'b0;
      end else begin
         lfc_sync <= {lfc_sync[0], low_freq_clock};
         lfc_prev <= lfc_sync[1];
      end
   end

   // gear clock divider; wraps round if the rate field shrinks mid-count
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         div_cnt <= 4'h0;
      else
         div_cnt <= hs_tick ? 4'h0 : div_cnt + 4'h1;
   end

   // counts low clock edges; every fourth one is a sampling instant
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         lf_cnt <= 2'h0;
      else if (lf_rise)
         lf_cnt <= lf_cnt + 2'h1;
   end

   // canceller: two equal consecutive samples move the pass signal
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         last_sample <= 1'b0;
         pass <= 1'b0;
         pass_prev <= 1'b0;
      end else begin
         pass_prev <= pass;
         if (tick) begin
            last_sample <= pin_sync[1];
            if (pin_sync[1] == last_sample)
               pass <= last_sample;
         end
      end
   end

   // rate and edge fields from software; level bit follows each request
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_irq1_control_reg <= eirqnf_pkg::CTRL_RST;
      end else begin
         if (wr_ctrl)
            ext_irq1_control_reg[3:0] <= writedata[3:0];
         if (edge_hit)
            ext_irq1_control_reg[eirqnf_pkg::LVL_BIT] <= pass;
      end
   end

   // mask has the layout of status
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         mask <= eirqnf_pkg::MASK_RST;
      else
         mask <= next_mask;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         low_speed <= eirqnf_pkg::MODE_RST;
      else if (wr_mode)
         low_speed <= writedata[0];
   end

   // sticky events; a set in the clearing cycle wins
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         status <= eirqnf_pkg::STATUS_RST;
      else
         status <= next_status;
   end

   // one-cycle request per selected edge
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         ext_irq1_req <= 1'b0;
      else
         ext_irq1_req <= edge_hit;
   end

   // level interrupt from the values the registers take at this edge
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         irq <= 1'b0;
      else
         irq <= |(next_status & next_mask);
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_state <= eirqnf_pkg::BUS_IDLE;
      end else begin
         case (bus_state)
            eirqnf_pkg::BUS_IDLE: begin
               if (read | write)
                  bus_state <= eirqnf_pkg::BUS_ACK;
            end
            eirqnf_pkg::BUS_ACK: bus_state <= eirqnf_pkg::BUS_IDLE;
            default: bus_state <= eirqnf_pkg::BUS_IDLE;
         endcase
      end
   end

   // captured one edge early so the data stand in the answer cycle
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         readdata <= 32'h0;
      else if (bus_new && read)
         readdata <= next_readdata;
   end
endmodule // eirqnf_top
`default_nettype wire
